/* include/timer_base_pkg.sv */
/*
 * Shared constants and types for the dual general-purpose timer time base.
 * Assumes a single 250 MHz clock domain and that every input is synchronous to it.
 */
package timer_base_pkg;
	localparam int CNT_W = 16;
	localparam int EXP_W = 4;
	localparam int NUM_TIMERS = 2;
	localparam int NUM_CHANNELS = 4;
	localparam int NUM_PINS = 12;
	// pin banks: timer one fixed, timer two default bank, timer two remapped bank
	localparam int PIN_BANK_ONE = 0;
	localparam int PIN_BANK_TWO_DEFAULT = 4;
	localparam int PIN_BANK_TWO_REMAP = 8;
	localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
	localparam logic [CNT_W-1:0] RST_RELOAD = 16'hffff;
	localparam logic [EXP_W-1:0] RST_EXPONENT = 4'h0;
	localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;

	typedef enum logic [1:0] {
		MODE_UP,
		MODE_DOWN,
		MODE_CENTER,
		MODE_RESERVED
	} count_mode_t;

	typedef enum logic [1:0] {
		SRC_PERIPHERAL,
		SRC_EXT_32K,
		SRC_1K,
		SRC_GPIO
	} clock_source_t;

	// terminal count of the prescaler for a divide ratio of two to the exponent
	function automatic logic [CNT_W-1:0] prescale_limit(input logic [EXP_W-1:0] exponent);
		logic [31:0] full;
		full = (32'd1 << exponent) - 32'd1;
		return full[CNT_W-1:0];
	endfunction : prescale_limit
endpackage : timer_base_pkg

/* src/prescale_divider.sv */
/*
 * Power-of-two prescaler built on a 16-bit counter; emits one tick per 2^exponent input ticks.
 * Assumes the exponent comes from a shadow copy that only changes on an update event.
 */
`timescale 1ns/1ps
module prescale_divider
	import timer_base_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic enable_i,
	input wire logic tick_i,
	input wire logic restart_i,
	input wire logic [EXP_W-1:0] exponent_i,
	output logic tick_o
);
	logic [CNT_W-1:0] count;
	logic at_limit;

	assign at_limit = (count == prescale_limit(exponent_i));
	// combinational so the main counter steps in the same cycle as the terminal count
	assign tick_o = enable_i & tick_i & at_limit & ~restart_i;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count <= RST_COUNT;
		end else if (restart_i) begin
			count <= RST_COUNT;
		end else if (enable_i && tick_i) begin
			count <= at_limit ? RST_COUNT : count + COUNT_ONE;
		end
	end
endmodule : prescale_divider

/* src/general_timer_time_base.sv */
/*
 * Time base of two identical, independent general-purpose timers plus their output pin mux.
 * Assumes software control bits arrive as plain synchronous ports and write strobes last one cycle.
 * Channel capture/compare logic lives outside; its outputs and enables arrive on channel ports.
 */
// Summary of operation
// [RL1] 16-bit reload counter counts up, down, center
// [RL2] prescaler divides by two to exponent
// [RL3] new exponent applies from next update event
// [RL4] counter, reload, prescaler always readable and writable
// [RL5] reload buffer feeds active copy per enable
// [RL6] overflow/underflow gives update unless disabled
// [RL7] counter steps only on enabled prescaler tick
// [RL8] internal enable lags enable bit one cycle
// [RL9] counters keep running during debug halt
// [RL10] up mode wraps reload to zero, overflow
// [RL11] update from overflow, software or slave
// [RL12] update disable blocks overflow/underflow updates and reloads; forced updates still load
// [RL13] forced update restarts counter and prescaler
// [RL14] request source hides flag on forced update
// [RL15] update sets flag, loads prescaler and reload
// [RL16] four channels per timer drive pins
// [RL17] update event raises the update flag
// [RL18] enabled timer output owns its shared pin
// [RL19] second timer remaps each channel to port B
// [RL20] clock and mask pins act only externally
// [RL21] independent timers with a sync path
// [RL22] clock from peripheral, 32k, 1k or gpio
// [RL23] down mode wraps zero to reload, underflow
// [RL24] update generate strobe is self clearing
// [RL25] update applies in the overflow cycle
`timescale 1ns/1ps
module general_timer_time_base
	import timer_base_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [NUM_TIMERS-1:0] counter_enable_bit_i,
	input wire logic [NUM_TIMERS-1:0] update_disable_i,
	input wire logic [NUM_TIMERS-1:0] update_request_source_i,
	input wire logic [NUM_TIMERS-1:0] reload_buffer_enable_i,
	input wire logic [NUM_TIMERS-1:0][1:0] count_mode_i,
	input wire logic [NUM_TIMERS-1:0][1:0] clock_source_i,
	input wire logic [NUM_TIMERS-1:0] sync_to_other_i,
	input wire logic [NUM_TIMERS-1:0] update_generate_i,
	input wire logic [NUM_TIMERS-1:0] slave_update_i,
	input wire logic [NUM_TIMERS-1:0] flag_clear_i,
	input wire logic [NUM_TIMERS-1:0] count_write_i,
	input wire logic [NUM_TIMERS-1:0][CNT_W-1:0] count_wdata_i,
	input wire logic [NUM_TIMERS-1:0] reload_write_i,
	input wire logic [NUM_TIMERS-1:0][CNT_W-1:0] reload_wdata_i,
	input wire logic [NUM_TIMERS-1:0] prescale_write_i,
	input wire logic [NUM_TIMERS-1:0][EXP_W-1:0] prescale_wdata_i,
	input wire logic ext_32k_tick_i,
	input wire logic ext_1k_tick_i,
	input wire logic [NUM_TIMERS-1:0] external_clock_pin_i,
	input wire logic [NUM_TIMERS-1:0] clock_mask_pin_i,
	input wire logic [NUM_TIMERS-1:0][NUM_CHANNELS-1:0] channel_out_i,
	input wire logic [NUM_TIMERS-1:0][NUM_CHANNELS-1:0] channel_out_enable_i,
	input wire logic [NUM_CHANNELS-1:0] channel_pin_remap_i,
	input wire logic [NUM_PINS-1:0] shared_out_i,
	input wire logic [NUM_PINS-1:0] shared_oe_i,
	output logic [NUM_TIMERS-1:0][CNT_W-1:0] count_value_o,
	output logic [NUM_TIMERS-1:0][CNT_W-1:0] reload_value_o,
	output logic [NUM_TIMERS-1:0][EXP_W-1:0] prescale_exponent_o,
	output logic [NUM_TIMERS-1:0] internal_count_enable_o,
	output logic [NUM_TIMERS-1:0] count_down_o,
	output logic [NUM_TIMERS-1:0] update_event_o,
	output logic [NUM_TIMERS-1:0] update_interrupt_flag_o,
	output logic [NUM_PINS-1:0] pin_out_o,
	output logic [NUM_PINS-1:0] pin_oe_o
);
	// combinational update strobes, crossed between the timers for the sync path
	logic [NUM_TIMERS-1:0] update_now;

	for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
		logic [CNT_W-1:0] count;
		logic [CNT_W-1:0] reload_buffer;
		logic [CNT_W-1:0] reload_shadow;
		logic [EXP_W-1:0] prescale_buffer;
		logic [EXP_W-1:0] prescale_shadow;
		logic count_enable;
		logic direction_down;
		logic flag;
		logic ext_pin_prev;
		logic source_tick;
		logic counter_tick_clock;
		logic overflow;
		logic underflow;
		logic [CNT_W-1:0] next_count;
		logic next_direction_down;
		logic [CNT_W-1:0] active_reload;
		logic [CNT_W-1:0] next_reload;
		logic sw_update;
		logic hw_update;
		count_mode_t mode;
		clock_source_t source;

		assign mode = count_mode_t'(count_mode_i[t]);
		assign source = clock_source_t'(clock_source_i[t]);

		// without buffering the buffer is the active value, continuously
		assign active_reload = reload_buffer_enable_i[t] ? reload_shadow : reload_buffer; // see [RL5]

		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				count_enable <= 1'b0;
			end else begin
				count_enable <= counter_enable_bit_i[t]; // see [RL8]
			end
		end

		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				ext_pin_prev <= 1'b0;
			end else begin
				ext_pin_prev <= external_clock_pin_i[t];
			end
		end

		// the sync path lets the other timer's update act as this timer's clock
		always_comb begin
			source_tick = 1'b0;
			if (sync_to_other_i[t]) begin
				source_tick = update_now[NUM_TIMERS-1-t]; // see [RL21]
			end else begin
				unique case (source) // see [RL22]
					SRC_PERIPHERAL: source_tick = 1'b1;
					SRC_EXT_32K: source_tick = ext_32k_tick_i;
					SRC_1K: source_tick = ext_1k_tick_i;
					// clock and mask pins are looked at only in this mode
					SRC_GPIO: source_tick = external_clock_pin_i[t] & ~ext_pin_prev
						& ~clock_mask_pin_i[t]; // see [RL20]
				endcase
			end
		end

		prescale_divider u_prescale (
			.clk_i(clk_i),
			.arst_n_i(arst_n_i),
			.enable_i(count_enable), // see [RL7]
			.tick_i(source_tick),
			.restart_i(sw_update), // see [RL13]
			.exponent_i(prescale_shadow), // see [RL2]
			.tick_o(counter_tick_clock)
		);

		// no debug halt input exists, so a debug halt cannot freeze the count
		always_comb begin
			next_count = count;
			next_direction_down = direction_down;
			overflow = 1'b0;
			underflow = 1'b0;
			if (counter_tick_clock) begin // see [RL7] see [RL9]
				unique case (mode) // see [RL1]
					MODE_UP: begin
						next_direction_down = 1'b0;
						if (count == active_reload) begin
							next_count = RST_COUNT; // see [RL10]
							overflow = 1'b1;
						end else begin
							next_count = count + COUNT_ONE;
						end
					end
					MODE_DOWN: begin
						next_direction_down = 1'b1;
						if (count == RST_COUNT) begin
							next_count = next_reload; // see [RL23]
							underflow = 1'b1;
						end else begin
							next_count = count - COUNT_ONE;
						end
					end
					MODE_CENTER: begin
						if (!direction_down) begin
							next_count = count + COUNT_ONE;
							if (next_count >= active_reload) begin
								overflow = 1'b1;
								next_direction_down = 1'b1;
							end
						end else begin
							next_count = count - COUNT_ONE;
							if (count <= COUNT_ONE) begin
								next_count = RST_COUNT;
								underflow = 1'b1;
								next_direction_down = 1'b0;
							end
						end
					end
					default: begin
						next_count = count;
					end
				endcase
			end
		end

		// forced updates come from software or the slave controller and ignore the disable bit
		assign sw_update = update_generate_i[t] | slave_update_i[t]; // see [RL11] see [RL24]
		assign hw_update = (overflow | underflow) & ~update_disable_i[t]; // see [RL6] see [RL12]
		assign update_now[t] = sw_update | hw_update;

		// a down count reloads from the value that this same update installs
		assign next_reload = (reload_buffer_enable_i[t] && !update_disable_i[t])
			? reload_buffer : active_reload; // see [RL25]

		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				count <= RST_COUNT;
				direction_down <= 1'b0;
			end else if (sw_update) begin
				count <= (mode == MODE_DOWN) ? reload_buffer : RST_COUNT; // see [RL13]
				direction_down <= (mode == MODE_DOWN);
			end else if (count_write_i[t]) begin
				count <= count_wdata_i[t]; // see [RL4]
			end else begin
				count <= next_count;
				direction_down <= next_direction_down;
			end
		end

		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				reload_buffer <= RST_RELOAD;
				prescale_buffer <= RST_EXPONENT;
			end else begin
				if (reload_write_i[t]) begin
					reload_buffer <= reload_wdata_i[t]; // see [RL4] see [RL5]
				end
				if (prescale_write_i[t]) begin
					prescale_buffer <= prescale_wdata_i[t]; // see [RL4] see [RL3]
				end
			end
		end

		// shadows move only on an update, so a disabled update leaves them alone
		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				reload_shadow <= RST_RELOAD;
				prescale_shadow <= RST_EXPONENT;
			end else if (update_now[t]) begin
				reload_shadow <= reload_buffer; // see [RL15] see [RL12]
				prescale_shadow <= prescale_buffer; // see [RL3] see [RL15]
			end
		end

		// a set arriving with a clear wins, so no event is lost
		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				flag <= 1'b0;
			end else if (hw_update || (sw_update && !update_request_source_i[t])) begin
				flag <= 1'b1; // see [RL14] see [RL15] see [RL17]
			end else if (flag_clear_i[t]) begin
				flag <= 1'b0;
			end
		end

		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				update_event_o[t] <= 1'b0;
			end else begin
				update_event_o[t] <= update_now[t];
			end
		end

		assign count_value_o[t] = count;
		assign reload_value_o[t] = reload_buffer;
		assign prescale_exponent_o[t] = prescale_buffer;
		assign internal_count_enable_o[t] = count_enable;
		assign count_down_o[t] = direction_down;
		assign update_interrupt_flag_o[t] = flag;
	end

	// timer output takes the pin whenever its channel is an enabled output
	for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_pins
		logic one_drive;
		logic two_default;
		logic two_remap;

		assign one_drive = channel_out_enable_i[0][c];
		assign two_default = channel_out_enable_i[1][c] & ~channel_pin_remap_i[c]; // see [RL19]
		assign two_remap = channel_out_enable_i[1][c] & channel_pin_remap_i[c]; // see [RL19]

		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				pin_out_o[PIN_BANK_ONE + c] <= 1'b0;
				pin_oe_o[PIN_BANK_ONE + c] <= 1'b0;
			end else begin
				pin_out_o[PIN_BANK_ONE + c] <= one_drive ? channel_out_i[0][c]
					: shared_out_i[PIN_BANK_ONE + c]; // see [RL18] see [RL16]
				pin_oe_o[PIN_BANK_ONE + c] <= one_drive | shared_oe_i[PIN_BANK_ONE + c];
			end
		end

		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				pin_out_o[PIN_BANK_TWO_DEFAULT + c] <= 1'b0;
				pin_oe_o[PIN_BANK_TWO_DEFAULT + c] <= 1'b0;
			end else begin
				pin_out_o[PIN_BANK_TWO_DEFAULT + c] <= two_default ? channel_out_i[1][c]
					: shared_out_i[PIN_BANK_TWO_DEFAULT + c]; // see [RL18]
				pin_oe_o[PIN_BANK_TWO_DEFAULT + c] <= two_default
					| shared_oe_i[PIN_BANK_TWO_DEFAULT + c];
			end
		end

		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				pin_out_o[PIN_BANK_TWO_REMAP + c] <= 1'b0;
				pin_oe_o[PIN_BANK_TWO_REMAP + c] <= 1'b0;
			end else begin
				pin_out_o[PIN_BANK_TWO_REMAP + c] <= two_remap ? channel_out_i[1][c]
					: shared_out_i[PIN_BANK_TWO_REMAP + c]; // see [RL18]
				pin_oe_o[PIN_BANK_TWO_REMAP + c] <= two_remap
					| shared_oe_i[PIN_BANK_TWO_REMAP + c];
			end
		end
	end
endmodule : general_timer_time_base

/* tb/timer_base_sva.sv */
/* assertions on the time base ports, timer 0 and the channel 0 pins
   assumes binding into general_timer_time_base, one clock domain */
`timescale 1ns/1ps
module timer_base_sva
	import timer_base_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [NUM_TIMERS-1:0] counter_enable_bit_i,
	input wire logic [NUM_TIMERS-1:0] update_disable_i,
	input wire logic [NUM_TIMERS-1:0] update_request_source_i,
	input wire logic [NUM_TIMERS-1:0] update_generate_i,
	input wire logic [NUM_TIMERS-1:0] slave_update_i,
	input wire logic [NUM_TIMERS-1:0] flag_clear_i,
	input wire logic [NUM_TIMERS-1:0] count_write_i,
	input wire logic [NUM_TIMERS-1:0][1:0] count_mode_i,
	input wire logic [NUM_TIMERS-1:0] reload_write_i,
	input wire logic [NUM_TIMERS-1:0][CNT_W-1:0] reload_wdata_i,
	input wire logic [NUM_TIMERS-1:0][NUM_CHANNELS-1:0] channel_out_i,
	input wire logic [NUM_TIMERS-1:0][NUM_CHANNELS-1:0] channel_out_enable_i,
	input wire logic [NUM_CHANNELS-1:0] channel_pin_remap_i,
	input wire logic [NUM_TIMERS-1:0][CNT_W-1:0] count_value_o,
	input wire logic [NUM_TIMERS-1:0][CNT_W-1:0] reload_value_o,
	input wire logic [NUM_TIMERS-1:0] internal_count_enable_o,
	input wire logic [NUM_TIMERS-1:0] update_event_o,
	input wire logic [NUM_TIMERS-1:0] update_interrupt_flag_o,
	input wire logic [NUM_PINS-1:0] pin_out_o,
	input wire logic [NUM_PINS-1:0] pin_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	logic quiet;
	// no software action that may move the count on its own
	assign quiet = !update_generate_i[0] && !slave_update_i[0] && !count_write_i[0];
	sequence forced_s;
		update_generate_i[0] || slave_update_i[0];
	endsequence
	sequence event_s;
		##1 update_event_o[0];
	endsequence
	enable_lag_a: assert property ($rose(counter_enable_bit_i[0]) |=> internal_count_enable_o[0])
		else $error("internal enable did not follow");
	forced_event_a: assert property (forced_s |-> event_s)
		else $error("forced update gave no event");
	forced_zero_a: assert property (update_generate_i[0] && count_mode_i[0] == 2'h0 |=>
		count_value_o[0] == 16'h0000) else $error("forced update did not clear count");
	flag_set_a: assert property (update_event_o[0] && !$past(update_request_source_i[0]) &&
		!$past(flag_clear_i[0]) |-> update_interrupt_flag_o[0]) else $error("flag missing");
	// the event register lags the update decision by one cycle
	udis_block_a: assert property ($past(update_disable_i[0]) && $past(quiet) |->
		!update_event_o[0]) else $error("event while updates disabled");
	count_hold_a: assert property (!$past(internal_count_enable_o[0]) && $past(quiet) |->
		$stable(count_value_o[0])) else $error("count moved while disabled");
	count_step_a: assert property ($changed(count_value_o[0]) && $past(count_mode_i[0]) == 2'h0 &&
		$past(quiet) |-> count_value_o[0] == 16'h0000 ||
		count_value_o[0] - $past(count_value_o[0]) == 16'h0001) else $error("bad up step");
	reload_read_a: assert property (reload_write_i[0] |=>
		reload_value_o[0] == $past(reload_wdata_i[0])) else $error("reload readback wrong");
	pin_own_a: assert property (channel_out_enable_i[0][0] |=> pin_oe_o[0] &&
		pin_out_o[0] == $past(channel_out_i[0][0])) else $error("timer lost its pin");
	pin_remap_a: assert property (channel_out_enable_i[1][0] && channel_pin_remap_i[0] |=>
		pin_oe_o[8] && pin_out_o[8] == $past(channel_out_i[1][0])) else $error("remap pin wrong");
	pin_default_a: assert property (channel_out_enable_i[1][0] && !channel_pin_remap_i[0] |=>
		pin_oe_o[4] && pin_out_o[4] == $past(channel_out_i[1][0])) else $error("default pin wrong");
endmodule : timer_base_sva

/* tb/timer_far_side.sv */
/* far-side model: external tick strobes and gpio clock and mask levels
   assumes the bench clock and reset */
`timescale 1ns/1ps
module timer_far_side (
	input wire logic clk_i,
	input wire logic arst_n_i,
	output logic ext_32k_tick_o,
	output logic ext_1k_tick_o,
	output logic [1:0] gpio_clock_o,
	output logic [1:0] gpio_mask_o
);
	logic [7:0] div;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div <= 8'h00;
		end else begin
			div <= div + 8'h01;
		end
	end
	// strobes far faster than the real sources, to keep runs short
	assign ext_32k_tick_o = div[2:0] == 3'h7;
	assign ext_1k_tick_o = div == 8'hff;
	assign gpio_clock_o = div[4:3];
	assign gpio_mask_o = div[7:6];
endmodule : timer_far_side

/* tb/general_timer_time_base_tb_top.sv */
/* self-checking bench for the dual timer time base, timer 0 and pins
   assumes the far-side model drives the tick and gpio inputs */
`timescale 1ns/1ps
module general_timer_time_base_tb_top
	import timer_base_pkg::*;
;
	logic clk_i, arst_n_i, ext_32k_tick_i, ext_1k_tick_i;
	logic [NUM_TIMERS-1:0] counter_enable_bit_i, update_disable_i, update_request_source_i;
	logic [NUM_TIMERS-1:0] reload_buffer_enable_i, sync_to_other_i, update_generate_i;
	logic [NUM_TIMERS-1:0] slave_update_i, flag_clear_i, count_write_i, reload_write_i;
	logic [NUM_TIMERS-1:0] prescale_write_i, external_clock_pin_i, clock_mask_pin_i;
	logic [NUM_TIMERS-1:0] internal_count_enable_o, count_down_o, update_event_o;
	logic [NUM_TIMERS-1:0] update_interrupt_flag_o;
	logic [NUM_TIMERS-1:0][1:0] count_mode_i, clock_source_i;
	logic [NUM_TIMERS-1:0][CNT_W-1:0] count_wdata_i, reload_wdata_i, count_value_o, reload_value_o;
	logic [NUM_TIMERS-1:0][EXP_W-1:0] prescale_wdata_i, prescale_exponent_o;
	logic [NUM_TIMERS-1:0][NUM_CHANNELS-1:0] channel_out_i, channel_out_enable_i;
	logic [NUM_CHANNELS-1:0] channel_pin_remap_i;
	logic [NUM_PINS-1:0] shared_out_i, shared_oe_i, pin_out_o, pin_oe_o, en, ch;
	logic [EXP_W-1:0] e;
	logic note_q[$];
	int error_cnt, num_checks, gap;
	general_timer_time_base general_timer_time_base_inst (.*);
	timer_far_side timer_far_side_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.ext_32k_tick_o(ext_32k_tick_i), .ext_1k_tick_o(ext_1k_tick_i),
		.gpio_clock_o(external_clock_pin_i), .gpio_mask_o(clock_mask_pin_i));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict
	task automatic wait_event(output int n);
		n = 0;
		while (update_event_o[0] !== 1'b1) begin
			step(1);
			n++;
			if (n > 2000) begin
				error_cnt++;
				print_verdict();
			end
		end
	endtask : wait_event
	// an event with no note pending is itself a mismatch
	always @(posedge clk_i) begin
		if (update_event_o[0] === 1'b1) begin
			if (note_q.size() == 0) begin
				check(16'h0001, 16'h0000);
			end else begin
				check(16'(update_interrupt_flag_o[0]), 16'(note_q.pop_front()));
			end
		end
	end
	initial begin
		error_cnt = 0;
		num_checks = 0;
		void'($urandom(50));
		arst_n_i = 1'b0;
		{counter_enable_bit_i, update_disable_i, update_request_source_i, reload_buffer_enable_i,
			sync_to_other_i, update_generate_i, slave_update_i, flag_clear_i, count_write_i,
			reload_write_i, prescale_write_i, channel_pin_remap_i} = '0;
		{count_mode_i, clock_source_i, count_wdata_i, reload_wdata_i, prescale_wdata_i} = '0;
		{channel_out_i, channel_out_enable_i, shared_out_i, shared_oe_i} = '0;
		step(12);
		arst_n_i = 1'b1;
		step(1);
		check(count_value_o[0], RST_COUNT);
		check(reload_value_o[0], RST_RELOAD);
		check(16'(prescale_exponent_o[0]), 16'(RST_EXPONENT));
		check(16'(pin_oe_o), 16'h0000);
		for (int k = 0; k < 2; k++) begin
			count_wdata_i[0] = k ? 16'h0000 : 16'($urandom);
			count_write_i = 2'b01;
			step(1);
			count_write_i = 2'b00;
			check(count_value_o[0], count_wdata_i[0]);
		end
		$display("test reset and writes done");
		reload_wdata_i[0] = 16'h0002;
		reload_write_i = 2'b01;
		step(1);
		reload_write_i = 2'b00;
		check(reload_value_o[0], 16'h0002);
		note_q.push_back(1'b1);
		counter_enable_bit_i = 2'b01;
		step(1);
		check(16'(internal_count_enable_o[0]), 16'h0001);
		for (int k = 1; k < 4; k++) begin
			step(1);
			check(count_value_o[0], 16'(k % 3));
		end
		check(16'(update_interrupt_flag_o[0]), 16'h0001);
		counter_enable_bit_i = 2'b00;
		step(3);
		$display("test up walk done");
		for (int k = 0; k < 2; k++) begin
			e = 4'($urandom_range(3, 1));
			prescale_wdata_i[0] = e;
			prescale_write_i = 2'b01;
			reload_buffer_enable_i = 2'(k);
			update_request_source_i = 2'(k);
			flag_clear_i = 2'b01;
			step(1);
			prescale_write_i = 2'b00;
			flag_clear_i = 2'b00;
			check(16'(prescale_exponent_o[0]), 16'(e));
			note_q.push_back(!k);
			update_generate_i = 2'b01;
			step(1);
			update_generate_i = 2'b00;
			check(count_value_o[0], 16'h0000);
			check(16'(update_interrupt_flag_o[0]), 16'(!k));
			step(3);
			update_request_source_i = 2'b00;
			note_q.push_back(1'b1);
			note_q.push_back(1'b1);
			counter_enable_bit_i = 2'b01;
			wait_event(gap);
			step(1);
			wait_event(gap);
			check(16'(gap + 1), 16'(3 << e));
			counter_enable_bit_i = 2'b00;
			step(2);
		end
		$display("test prescaler done");
		flag_clear_i = 2'b01;
		update_disable_i = 2'b01;
		step(1);
		flag_clear_i = 2'b00;
		counter_enable_bit_i = 2'b01;
		step(60);
		check(16'(update_interrupt_flag_o[0]), 16'h0000);
		counter_enable_bit_i = 2'b00;
		step(2);
		update_disable_i = 2'b00;
		note_q.push_back(1'b1);
		slave_update_i = 2'b01;
		step(1);
		slave_update_i = 2'b00;
		step(3);
		check(16'(update_interrupt_flag_o[0]), 16'h0001);
		$display("test update sources done");
		for (int k = 0; k < 4; k++) begin
			{channel_out_i, channel_out_enable_i, channel_pin_remap_i} = 20'($urandom);
			{shared_out_i, shared_oe_i} = 24'($urandom);
			channel_out_enable_i[0][0] = 1'b1;
			channel_out_enable_i[1][0] = 1'b1;
			channel_pin_remap_i[0] = k[0];
			step(1);
			en = {channel_out_enable_i[1] & channel_pin_remap_i,
				channel_out_enable_i[1] & ~channel_pin_remap_i, channel_out_enable_i[0]};
			ch = {channel_out_i[1], channel_out_i[1], channel_out_i[0]};
			ch = ((en & ch) | (~en & shared_out_i)) & (en | shared_oe_i);
			check(16'(pin_oe_o), 16'(en | shared_oe_i));
			check(16'(pin_out_o & pin_oe_o), 16'(ch));
		end
		$display("test pins done");
		check(16'(note_q.size()), 16'h0000);
		print_verdict();
	end
endmodule : general_timer_time_base_tb_top
bind general_timer_time_base timer_base_sva timer_base_sva_inst (.*);
